// ===== verilog/trcap_pkg.sv
/*
 Package for the trace resource capability register block: field
 positions, field values, access encoding, privilege levels, outcomes.
 Assumes nothing of its surroundings.
*/
package trcap_pkg;

   localparam int REG_W = 64;

   // Field positions (low bit) and field width
   localparam int FLD_W        = 4;
   localparam int POS_VCTX     = 28;
   localparam int POS_CTX      = 24;
   localparam int POS_SSHOT    = 20;
   localparam int POS_RSPAIR   = 16;
   localparam int POS_PECMP    = 12;
   localparam int POS_DADDR    = 8;
   localparam int POS_DVAL     = 4;
   localparam int POS_ACPAIR   = 0;

   // Field values
   localparam logic [3:0] VAL_VCTX   = 4'h1;
   localparam logic [3:0] VAL_CTX    = 4'h1;
   localparam logic [3:0] VAL_SSHOT  = 4'h1;
   localparam logic [3:0] VAL_RSPAIR = 4'h7;
   localparam logic [3:0] VAL_PECMP  = 4'h0;
   localparam logic       VAL_DADDR  = 1'h0;
   localparam logic [3:0] VAL_DVAL   = 4'h0;
   localparam logic [3:0] VAL_ACPAIR = 4'h4;

   // Reset values of the read data, syndrome and destination registers
   localparam logic [63:0] RDATA_RST = 64'h0;
   localparam logic [5:0]  SYND_RST  = 6'h0;
   localparam logic [4:0]  DEST_RST  = 5'h0;

   // System register read encoding
   localparam logic [1:0] ENC_OP0 = 2'h2;
   localparam logic [2:0] ENC_OP1 = 3'h1;
   localparam logic [3:0] ENC_CRN = 4'h0;
   localparam logic [3:0] ENC_CRM = 4'hc;
   localparam logic [2:0] ENC_OP2 = 3'h7;

   // Syndrome class of a trace access trap
   localparam logic [5:0] SYND_TRACE = 6'h18;

   localparam logic [1:0] LVL0 = 2'h0;
   localparam logic [1:0] LVL1 = 2'h1;
   localparam logic [1:0] LVL2 = 2'h2;
   localparam logic [1:0] LVL3 = 2'h3;

   typedef enum logic [3:0] {
      RES_VALUE = 4'b0001,
      RES_UNDEF = 4'b0010,
      RES_TRAP  = 4'b0100,
      RES_NONE  = 4'b1000
   } trcap_result_type;

endpackage

// ===== verilog/trcap_access_check.sv
/*
 Privilege check for a read of the capability register. Purely
 combinational; decides value, undefined or trap and the trap target.
 Assumes the core presents its privilege and trap-control state as levels.
*/
`timescale 1ns/10ps
module trcap_access_check
   import trcap_pkg::*;
(
   input  wire logic [1:0]       i_level,
   input  wire logic             i_halted,
   input  wire logic             i_sdbg_off,
   input  wire logic             i_trap1,
   input  wire logic             i_trap2,
   input  wire logic             i_trap3,
   input  wire logic             i_lvl2_en,
   input  wire logic             i_fgt_en,
   input  wire logic             i_fgt_id,
   output trcap_result_type      o_result,
   output logic [1:0]            o_target
);

   logic halt_sdbg;

   assign halt_sdbg = i_halted & i_sdbg_off;

   always_comb begin
      o_result = RES_VALUE;
      o_target = LVL0;
      case (i_level)
         LVL0: begin
            o_result = RES_UNDEF;
         end
         LVL1: begin
            if (halt_sdbg && i_trap3) begin
               o_result = RES_UNDEF;
            end else if (i_trap1) begin
               o_result = RES_TRAP;
               o_target = LVL1;
            end else if (i_lvl2_en && i_trap2) begin
               o_result = RES_TRAP;
               o_target = LVL2;
            end else if (i_lvl2_en && i_fgt_en && i_fgt_id) begin
               o_result = RES_TRAP;
               o_target = LVL2;
            end else if (i_trap3) begin
               o_result = RES_TRAP;
               o_target = LVL3;
            end
         end
         LVL2: begin
            if (halt_sdbg && i_trap3) begin
               o_result = RES_UNDEF;
            end else if (i_trap2) begin
               o_result = RES_TRAP;
               o_target = LVL2;
            end else if (i_trap3) begin
               o_result = RES_TRAP;
               o_target = LVL3;
            end
         end
         LVL3: begin
            if (i_trap3) begin
               o_result = RES_TRAP;
               o_target = LVL3;
            end
         end
         default: begin
            o_result = RES_UNDEF;
         end
      endcase
   end

endmodule

// ===== verilog/trcap_id_regs.sv
/*
 Trace resource capability identification register, read by the core's
 system register read instruction. Answers one cycle after the request.
 Assumes the core holds its privilege state stable with the request.
*/
`timescale 1ns/10ps
module trcap_id_regs
   import trcap_pkg::*;
(
   input  wire logic             I_CORE_CLK,
   input  wire logic             I_ARST_N,
   input  wire logic             I_RD_REQ,
   input  wire logic [1:0]       I_OP0,
   input  wire logic [2:0]       I_OP1,
   input  wire logic [3:0]       I_CRN,
   input  wire logic [3:0]       I_CRM,
   input  wire logic [2:0]       I_OP2,
   input  wire logic [4:0]       I_DEST_REG,
   input  wire logic [1:0]       I_CURRENT_PRIVILEGE_LEVEL,
   input  wire logic             I_HALTED,
   input  wire logic             I_SECURE_DEBUG_DISABLE_FLAG,
   input  wire logic             I_LVL1_TRACE_ACCESS_TRAP,
   input  wire logic             I_LVL2_TRACE_ACCESS_TRAP,
   input  wire logic             I_LVL3_TRACE_ACCESS_TRAP,
   input  wire logic             I_LVL2_ENABLED,
   input  wire logic             I_FINE_GRAIN_TRAP_ENABLE,
   input  wire logic             I_FINE_GRAIN_TRACE_ID_READ_TRAP,
   output logic                  O_HIT,
   output logic                  O_RD_VALID,
   output logic [63:0]           O_RD_DATA,
   output logic [4:0]            O_RD_DEST,
   output logic                  O_UNDEF,
   output logic                  O_TRAP,
   output logic [1:0]            O_TRAP_LEVEL,
   output logic [5:0]            O_TRAP_SYNDROME,
   output logic [31:0]           O_EXT_DEBUG_VIEW
);

   logic [63:0]      cap_value;
   logic             hit;
   trcap_result_type result;
   logic [1:0]       target;

   logic             valid_ff,  nxt_valid;
   logic             undef_ff,  nxt_undef;
   logic             trap_ff,   nxt_trap;
   logic [1:0]       tlvl_ff,   nxt_tlvl;
   logic [5:0]       synd_ff,   nxt_synd;
   logic [63:0]      data_ff,   nxt_data;
   logic [4:0]       dest_ff,   nxt_dest;

   // Constant capability word, no write path exists
   always_comb begin
      cap_value = '0;
      cap_value[POS_VCTX   +: FLD_W] = VAL_VCTX;
      cap_value[POS_CTX    +: FLD_W] = VAL_CTX;
      cap_value[POS_SSHOT  +: FLD_W] = VAL_SSHOT;
      cap_value[POS_RSPAIR +: FLD_W] = VAL_RSPAIR;
      cap_value[POS_PECMP  +: FLD_W] = VAL_PECMP;
      cap_value[POS_DADDR]           = VAL_DADDR;
      cap_value[POS_DVAL   +: FLD_W] = VAL_DVAL;
      cap_value[POS_ACPAIR +: FLD_W] = VAL_ACPAIR;
   end

   assign O_EXT_DEBUG_VIEW = cap_value[31:0];

   assign hit = I_RD_REQ && I_OP0 == ENC_OP0 && I_OP1 == ENC_OP1 &&
                I_CRN == ENC_CRN && I_CRM == ENC_CRM &&
                I_OP2 == ENC_OP2;
   assign O_HIT = hit;

   trcap_access_check u_check (
      .i_level  (I_CURRENT_PRIVILEGE_LEVEL),
      .i_halted (I_HALTED),
      .i_sdbg_off(I_SECURE_DEBUG_DISABLE_FLAG),
      .i_trap1  (I_LVL1_TRACE_ACCESS_TRAP),
      .i_trap2  (I_LVL2_TRACE_ACCESS_TRAP),
      .i_trap3  (I_LVL3_TRACE_ACCESS_TRAP),
      .i_lvl2_en(I_LVL2_ENABLED),
      .i_fgt_en (I_FINE_GRAIN_TRAP_ENABLE),
      .i_fgt_id (I_FINE_GRAIN_TRACE_ID_READ_TRAP),
      .o_result (result),
      .o_target (target)
   );

   // halted with secure debug off and the level 3 trap set falls into the undefined branch at level 1 or 2
   always_comb begin
      nxt_valid = 1'b0;
      nxt_undef = 1'b0;
      nxt_trap  = 1'b0;
      nxt_tlvl  = tlvl_ff;
      nxt_synd  = synd_ff;
      nxt_data  = RDATA_RST;
      nxt_dest  = dest_ff;
      if (hit) begin
         case (result)
            RES_VALUE: begin
               nxt_valid = 1'b1;
               nxt_data  = cap_value;
               nxt_dest  = I_DEST_REG;
            end
            RES_UNDEF: begin
               nxt_undef = 1'b1;
            end
            RES_TRAP: begin
               nxt_trap = 1'b1;
               nxt_tlvl = target;
               nxt_synd = SYND_TRACE;
            end
            default: begin
               nxt_undef = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         valid_ff <= 1'b0;
         undef_ff <= 1'b0;
         trap_ff  <= 1'b0;
         tlvl_ff  <= LVL0;
         synd_ff  <= SYND_RST;
         data_ff  <= RDATA_RST;
         dest_ff  <= DEST_RST;
      end else begin
         valid_ff <= nxt_valid;
         undef_ff <= nxt_undef;
         trap_ff  <= nxt_trap;
         tlvl_ff  <= nxt_tlvl;
         synd_ff  <= nxt_synd;
         data_ff  <= nxt_data;
         dest_ff  <= nxt_dest;
      end
   end

   assign O_RD_VALID      = valid_ff;
   assign O_RD_DATA       = data_ff;
   assign O_RD_DEST       = dest_ff;
   assign O_UNDEF         = undef_ff;
   assign O_TRAP          = trap_ff;
   assign O_TRAP_LEVEL    = tlvl_ff;
   assign O_TRAP_SYNDROME = synd_ff;

   // Checks
   logic             sec_halt_trap;
   logic             fine_trap;

   assign sec_halt_trap = I_HALTED && I_SECURE_DEBUG_DISABLE_FLAG &&
                          I_LVL3_TRACE_ACCESS_TRAP;
   assign fine_trap     = I_FINE_GRAIN_TRAP_ENABLE &&
                          I_FINE_GRAIN_TRACE_ID_READ_TRAP;

   // Decoded read at one privilege level
   sequence s_hit_at(logic [1:0] lv);
      hit && I_CURRENT_PRIVILEGE_LEVEL == lv;
   endsequence

   // Level 1 read past the undefined and own trap checks
   sequence s_l1_open;
      s_hit_at(LVL1) ##0 (!sec_halt_trap && !I_LVL1_TRACE_ACCESS_TRAP);
   endsequence

   // Level 2 read past the undefined check
   sequence s_l2_open;
      s_hit_at(LVL2) ##0 !sec_halt_trap;
   endsequence

   chk_vctx_field: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[31:28] == 4'h1)
      else $error("virtual context comparator count wrong");
   chk_ctx_field: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[27:24] == 4'h1)
      else $error("context comparator count wrong");
   chk_sshot_field: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[23:20] == 4'h1)
      else $error("single shot control count wrong");
   chk_rspair_field: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[19:16] == 4'h7)
      else $error("resource selector pair count wrong");
   chk_pecmp_field: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[15:12] == 4'h0)
      else $error("comparator input count wrong");
   chk_daddr_bit: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[8] == 1'h0)
      else $error("data address support bit wrong");
   chk_dval_field: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[7:4] == 4'h0)
      else $error("data value comparator count wrong");
   chk_low_nibble: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[3:0] == 4'h4)
      else $error("address pair count wrong");

   chk_value_fields: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA == 64'h0000_0000_1117_0004)
      else $error("capability value wrong");

   chk_reserved_zero: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_DATA[63:32] == 32'h0 && O_RD_DATA[11:9] == 3'h0)
      else $error("reserved bits not zero");

   chk_debug_view: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_RD_VALID |-> O_RD_DATA[31:0] == O_EXT_DEBUG_VIEW)
      else $error("debug view mismatch");

   chk_debug_const: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_EXT_DEBUG_VIEW == 32'h1117_0004)
      else $error("debug view value wrong");

   chk_one_answer: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      hit |=> $onehot({O_RD_VALID, O_UNDEF, O_TRAP}))
      else $error("not exactly one answer");

   chk_no_miss_ans: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      !hit |=> !O_RD_VALID && !O_UNDEF && !O_TRAP)
      else $error("answer without decode");

   chk_lvl0_undef: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_hit_at(LVL0) |=> O_UNDEF && !O_RD_VALID)
      else $error("level 0 read not undefined");

   chk_halted_undef: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      hit && I_CURRENT_PRIVILEGE_LEVEL != LVL3 && sec_halt_trap
      |=> O_UNDEF && !O_TRAP)
      else $error("halted secure read not undefined");

   chk_lvl1_trap: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_hit_at(LVL1) ##0 (I_LVL1_TRACE_ACCESS_TRAP && !sec_halt_trap)
      |=> O_TRAP && O_TRAP_LEVEL == LVL1 && O_TRAP_SYNDROME == SYND_TRACE)
      else $error("level 1 trap wrong");

   chk_lvl1_to_l2: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_l1_open ##0 (I_LVL2_ENABLED && I_LVL2_TRACE_ACCESS_TRAP)
      |=> O_TRAP && O_TRAP_LEVEL == LVL2)
      else $error("level 1 read not trapped to level 2");

   chk_fine_trap: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_l1_open ##0 (I_LVL2_ENABLED && !I_LVL2_TRACE_ACCESS_TRAP &&
      fine_trap) |=> O_TRAP && O_TRAP_LEVEL == LVL2)
      else $error("fine grained trap wrong");

   chk_lvl1_to_l3: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_l1_open ##0 (!(I_LVL2_ENABLED && (I_LVL2_TRACE_ACCESS_TRAP ||
      fine_trap)) && I_LVL3_TRACE_ACCESS_TRAP) |=> O_TRAP &&
      O_TRAP_LEVEL == LVL3)
      else $error("level 1 read not trapped to level 3");

   chk_lvl1_undef: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_hit_at(LVL1) ##0 sec_halt_trap |=> O_UNDEF && !O_TRAP)
      else $error("level 1 halted read not undefined");

   chk_lvl2_own_trap: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_l2_open ##0 I_LVL2_TRACE_ACCESS_TRAP |=> O_TRAP &&
      O_TRAP_LEVEL == LVL2)
      else $error("level 2 trap wrong");

   chk_lvl2_to_l3: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_l2_open ##0 (!I_LVL2_TRACE_ACCESS_TRAP && I_LVL3_TRACE_ACCESS_TRAP)
      |=> O_TRAP && O_TRAP_LEVEL == LVL3)
      else $error("level 2 read not trapped to level 3");

   chk_lvl3_trap: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_hit_at(LVL3) ##0 I_LVL3_TRACE_ACCESS_TRAP
      |=> O_TRAP && O_TRAP_LEVEL == LVL3 && !O_RD_VALID)
      else $error("level 3 trap wrong");

   chk_trap_synd: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_TRAP |-> O_TRAP_SYNDROME == 6'h18)
      else $error("trap syndrome wrong");

   chk_value_dest: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_hit_at(LVL3) ##0 !I_LVL3_TRACE_ACCESS_TRAP
      |=> O_RD_VALID && O_RD_DEST == $past(I_DEST_REG))
      else $error("value or destination wrong");

   chk_idle_data: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      !O_RD_VALID |-> O_RD_DATA == 64'h0)
      else $error("data not zero outside a read");

endmodule

// ===== tb/trcap_core_model.sv
/*
 Core model: issues system register reads with privilege state.
 Assumes the caller runs in step with the core clock.
*/
`timescale 1ns/10ps
module trcap_core_model (
   input  wire logic   i_clk,
   output logic        o_req,
   output logic [15:0] o_enc,
   output logic [4:0]  o_dest,
   output logic [1:0]  o_lvl,
   output logic [7:0]  o_ctl
);
   localparam logic [15:0] ENC = {2'h2, 3'h1, 4'h0, 4'hc, 3'h7};

   initial begin
      o_req = 1'b0;
      o_enc = 16'h0;
      o_dest = 5'h0;
      o_lvl = 2'h0;
      o_ctl = 8'h0;
   end

   // One request per call, launched at the falling edge
   task automatic issue(logic rq, logic ok, logic [4:0] d, logic [1:0] l,
         logic [7:0] c);
      @(negedge i_clk);
      o_req = rq;
      // Refused reads flip one bit of any encoding field
      o_enc = ok ? ENC : ENC ^ (16'h1 << c[3:0]);
      o_dest = d;
      o_lvl = l;
      o_ctl = c;
   endtask
endmodule

// ===== tb/tb.sv
/*
 Self-checking bench: random reads from the core model, expected outcomes
 queued and matched against the answers one cycle later.
 Assumes the answer comes exactly one cycle after the request is taken.
*/
`timescale 1ns/10ps
module tb;
   import trcap_pkg::*;
   typedef struct packed {
      logic [2:0] k;
      logic [1:0] l;
      logic [4:0] d;
   } trcap_note_type;
   localparam logic [63:0] EXPV = {32'h0, 4'h1, 4'h1, 4'h1,
      4'h7, 4'h0, 3'h0, 1'h0,
      4'h0, 4'h4};
   logic           clk = 1'b0;
   logic           rst_n = 1'b0;
   logic           req, hit, vld, und, trp;
   logic [1:0]     lvl, tlvl;
   logic [15:0]    enc;
   logic [4:0]     dest, rdest;
   logic [7:0]     ctl;
   logic [5:0]     synd;
   logic [63:0]    rdata;
   logic [31:0]    ext, r;
   logic [2:0]     ans;
   int             seed, n_mismatch, samples_checked, i;
   trcap_note_type q[$];

   assign ans = {vld, und, trp};
   always #2.5 clk = ~clk;

   trcap_core_model u_trcap_core_model (.i_clk(clk), .o_req(req),
      .o_enc(enc), .o_dest(dest), .o_lvl(lvl), .o_ctl(ctl));

   trcap_id_regs u_trcap_id_regs (.I_CORE_CLK(clk), .I_ARST_N(rst_n),
      .I_RD_REQ(req), .I_OP0(enc[15:14]), .I_OP1(enc[13:11]),
      .I_CRN(enc[10:7]), .I_CRM(enc[6:3]), .I_OP2(enc[2:0]),
      .I_DEST_REG(dest), .I_CURRENT_PRIVILEGE_LEVEL(lvl),
      .I_HALTED(ctl[7]), .I_SECURE_DEBUG_DISABLE_FLAG(ctl[6]),
      .I_LVL1_TRACE_ACCESS_TRAP(ctl[5]), .I_LVL2_TRACE_ACCESS_TRAP(ctl[4]),
      .I_LVL3_TRACE_ACCESS_TRAP(ctl[3]), .I_LVL2_ENABLED(ctl[2]),
      .I_FINE_GRAIN_TRAP_ENABLE(ctl[1]),
      .I_FINE_GRAIN_TRACE_ID_READ_TRAP(ctl[0]), .O_HIT(hit),
      .O_RD_VALID(vld), .O_RD_DATA(rdata), .O_RD_DEST(rdest),
      .O_UNDEF(und), .O_TRAP(trp), .O_TRAP_LEVEL(tlvl),
      .O_TRAP_SYNDROME(synd), .O_EXT_DEBUG_VIEW(ext));

   // Outcome codes: 100 value, 010 undefined, 001 trap
   function automatic trcap_note_type exp_note(logic [1:0] l,
         logic [7:0] c, logic [4:0] d);
      trcap_note_type e;
      e = {3'b100, 2'h0, d};
      if (l == 2'h0) e.k = 3'b010;
      else if (l != 2'h3 && c[7] && c[6] && c[3]) e.k = 3'b010;
      else if (l == 2'h1 && c[5]) e = {3'b001, 2'h1, d};
      else if (l == 2'h1 && c[2] && (c[4] | (c[1] & c[0])))
         e = {3'b001, 2'h2, d};
      else if (l == 2'h2 && c[4]) e = {3'b001, 2'h2, d};
      else if (c[3]) e = {3'b001, 2'h3, d};
      return e;
   endfunction

   task automatic cmp_flag(string nm, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (e !== g) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_data(string nm, logic [63:0] e, logic [63:0] g);
      samples_checked++;
      if (e !== g) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_answer;
      trcap_note_type n;
      if (q.size() == 0) begin
         cmp_flag("spare answer", 8'h0, {5'h0, ans});
         return;
      end
      n = q.pop_front();
      cmp_flag("ans", {5'h0, n.k}, {5'h0, ans});
      cmp_data("data", n.k[2] ? EXPV : 64'h0, rdata);
      if (n.k[2]) cmp_flag("dest", {3'h0, n.d}, {3'h0, rdest});
      if (n.k[0]) cmp_flag("lvl", {6'h0, n.l}, {6'h0, tlvl});
      if (n.k[0]) cmp_flag("synd", 8'h18, {2'h0, synd});
   endtask

   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Answers are looked at once the falling edge inputs have settled
   always @(negedge clk) begin
      #1;
      if (rst_n && ans != 3'h0) check_answer();
      else if (rst_n) cmp_data("idle data", 64'h0, rdata);
      cmp_data("debug view", {32'h0, EXPV[31:0]}, {32'h0, ext});
   end

   initial begin
      seed = 8625;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (i = 0; i < 600; i++) begin
         r = $random(seed);
         u_trcap_core_model.issue(r[0] | r[1], r[4:2] != 3'h0, r[19:15],
            r[6:5], r[14:7]);
         if ((r[0] | r[1]) && r[4:2] != 3'h0)
            q.push_back(exp_note(r[6:5], r[14:7], r[19:15]));
         #1 cmp_flag("hit", {7'h0, (r[0] | r[1]) && r[4:2] != 3'h0},
            {7'h0, hit});
      end
      u_trcap_core_model.issue(1'b0, 1'b0, 5'h0, 2'h0, 8'h0);
      repeat (2) @(negedge clk);
      cmp_flag("left", 8'h0, 8'(q.size()));
      $display("test random reads done");
      rst_n = 1'b0;
      #1 cmp_data("rst data", 64'h0, rdata);
      cmp_flag("rst flags", 8'h0, {ans, tlvl, 3'h0});
      cmp_flag("rst synd", 8'h0, {2'h0, synd});
      @(negedge clk);
      rst_n = 1'b1;
      u_trcap_core_model.issue(1'b1, 1'b1, 5'h1f, 2'h3, 8'h0);
      q.push_back(exp_note(2'h3, 8'h0, 5'h1f));
      u_trcap_core_model.issue(1'b0, 1'b0, 5'h0, 2'h0, 8'h0);
      repeat (2) @(negedge clk);
      cmp_flag("left", 8'h0, 8'(q.size()));
      $display("test reset and first read done");
      test_done();
   end

   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
endmodule
